// ===== design/epcr_config_regs.sv
// Eye-scan and pattern generator configuration bank with a point dwell timer.
// Assumes a host port decoded into word address, write strobe and read strobe.
//
// Operation
// - Rate field picks generator line rate.
// - Clock source 3 uses recovery rate instead.
// - Point time upper half, reset zero.
// - Point time lower half, reset 64h.
// - Each point measured twice.
// - Shape scan compares errors with threshold.
// - Default slice level, reset 128.
// - Clock source 0 oscillator, 3 recovered.
`timescale 1ns/1ps
`default_nettype none
`include "epcr_defines.svh"

module epcr_config_regs #(
	parameter int unsigned CYCLES_PER_US = `EPCR_CYCLES_PER_US
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [7:0]  host_addr,
	input  wire logic        host_wr,
	input  wire logic        host_rd,
	input  wire logic [15:0] host_wdata,
	input  wire logic [2:0]  cdr_rate,
	input  wire logic        point_start,
	input  wire logic        shape_scan,
	input  wire logic [15:0] point_error_count,
	output logic [15:0]      host_rdata,
	output logic [2:0]       pattern_rate_effective,
	output logic             pattern_clock_recovered,
	output logic [31:0]      point_time_us,
	output logic [7:0]       default_slice_level,
	output logic             eye_init,
	output logic [6:0]       phase_start,
	output logic [6:0]       phase_stop,
	output logic [6:0]       phase_step,
	output logic [6:0]       voltage_sweep_first,
	output logic             point_busy,
	output logic             point_done,
	output logic             point_bad
);
	typedef struct packed {
		epcr_pkg::epcr_word_t gen_ctrl;
		epcr_pkg::epcr_word_t reserved_after_pattern_gen_53;
		epcr_pkg::epcr_word_t time_hi;
		epcr_pkg::epcr_word_t time_lo;
		epcr_pkg::epcr_word_t threshold;
		epcr_pkg::epcr_word_t slice_init;
		epcr_pkg::epcr_word_t reserved_after_pattern_gen_58;
		epcr_pkg::epcr_word_t reserved_after_pattern_gen_59;
		epcr_pkg::epcr_word_t phase_win;
		epcr_pkg::epcr_word_t step_vert;
		epcr_pkg::epcr_word_t rdata;
		logic [2:0]           rate_eff;
		logic                 clk_rec;
		logic                 busy;
		logic                 done;
		logic                 bad;
	} epcr_regs_s;

	// A part-select cannot be taken of a literal, so the reset word gets a name first.
	localparam logic [15:0] GEN_CTRL_RST = `EPCR_RST_PATTERN_GEN_CONTROL;

	epcr_regs_s r_q;
	epcr_regs_s r_d;
	logic       tmr_busy;
	logic       tmr_done;
	logic [1:0] clk_src;
	logic       tmr_start;

	assign clk_src = r_q.gen_ctrl[`EPCR_CLKSRC_MSB:`EPCR_CLKSRC_LSB];
	// A new point is not accepted while one is still being timed.
	assign tmr_start = point_start && !tmr_busy;

	epcr_point_timer #(
		.CYCLES_PER_US (CYCLES_PER_US)
	) u_timer (
		.clk_sys       (clk_sys),
		.reset_n       (reset_n),
		.start         (tmr_start),
		.point_time_us (point_time_us),
		.busy          (tmr_busy),
		.done          (tmr_done)
	);

	always_comb begin
		r_d = r_q;
		// All registers are plain read/write; reserved words store whatever is written, as
		// the host is trusted to leave them alone.
		if (host_wr) begin
			unique case (host_addr)
				`EPCR_ADDR_PATTERN_GEN_CONTROL: r_d.gen_ctrl   = host_wdata;
				`EPCR_ADDR_RESERVED_AFTER_GEN:  r_d.reserved_after_pattern_gen_53    = host_wdata;
				`EPCR_ADDR_EYE_POINT_TIME_HIGH: r_d.time_hi    = host_wdata;
				`EPCR_ADDR_EYE_POINT_TIME_LOW:  r_d.time_lo    = host_wdata;
				`EPCR_ADDR_EYE_ERROR_THRESHOLD: r_d.threshold  = host_wdata;
				`EPCR_ADDR_EYE_SLICE_AND_INIT:  r_d.slice_init = host_wdata;
				`EPCR_ADDR_RESERVED_EYE_CFG_A:  r_d.reserved_after_pattern_gen_58    = host_wdata;
				`EPCR_ADDR_RESERVED_EYE_CFG_B:  r_d.reserved_after_pattern_gen_59    = host_wdata;
				`EPCR_ADDR_EYE_PHASE_WINDOW:    r_d.phase_win  = host_wdata;
				`EPCR_ADDR_EYE_PHASE_STEP_VERT: r_d.step_vert  = host_wdata;
				default: ;
			endcase
		end
		if (host_rd) begin
			unique case (host_addr)
				`EPCR_ADDR_PATTERN_GEN_CONTROL: r_d.rdata = r_q.gen_ctrl;
				`EPCR_ADDR_RESERVED_AFTER_GEN:  r_d.rdata = r_q.reserved_after_pattern_gen_53;
				`EPCR_ADDR_EYE_POINT_TIME_HIGH: r_d.rdata = r_q.time_hi;
				`EPCR_ADDR_EYE_POINT_TIME_LOW:  r_d.rdata = r_q.time_lo;
				`EPCR_ADDR_EYE_ERROR_THRESHOLD: r_d.rdata = r_q.threshold;
				`EPCR_ADDR_EYE_SLICE_AND_INIT:  r_d.rdata = r_q.slice_init;
				`EPCR_ADDR_RESERVED_EYE_CFG_A:  r_d.rdata = r_q.reserved_after_pattern_gen_58;
				`EPCR_ADDR_RESERVED_EYE_CFG_B:  r_d.rdata = r_q.reserved_after_pattern_gen_59;
				`EPCR_ADDR_EYE_PHASE_WINDOW:    r_d.rdata = r_q.phase_win;
				`EPCR_ADDR_EYE_PHASE_STEP_VERT: r_d.rdata = r_q.step_vert;
				default:                        r_d.rdata = 16'h0000;
			endcase
		end
		// Reserved clock-source codes 1 and 2 are treated as the free-running oscillator.
		r_d.clk_rec = (clk_src == `EPCR_CLKSRC_RECOVERED);
		if (clk_src == `EPCR_CLKSRC_RECOVERED) begin
			r_d.rate_eff = cdr_rate;
		end else begin
			r_d.rate_eff = r_q.gen_ctrl[`EPCR_RATE_MSB:`EPCR_RATE_LSB];
		end
		r_d.busy = tmr_busy;
		r_d.done = tmr_done;
		// The grade of a finishing point wins over the clear of a start in the same cycle.
		if (tmr_done) begin
			// Only a shape scan grades points; a plain scan reports the raw count elsewhere.
			r_d.bad = shape_scan && (point_error_count > r_q.threshold);
		end else if (tmr_start) begin
			r_d.bad = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r_q.gen_ctrl   <= `EPCR_RST_PATTERN_GEN_CONTROL;
			r_q.reserved_after_pattern_gen_53    <= `EPCR_RST_RESERVED_AFTER_GEN;
			r_q.time_hi    <= `EPCR_RST_EYE_POINT_TIME_HIGH;
			r_q.time_lo    <= `EPCR_RST_EYE_POINT_TIME_LOW;
			r_q.threshold  <= `EPCR_RST_EYE_ERROR_THRESHOLD;
			r_q.slice_init <= `EPCR_RST_EYE_SLICE_AND_INIT;
			r_q.reserved_after_pattern_gen_58    <= `EPCR_RST_RESERVED_EYE_CFG_A;
			r_q.reserved_after_pattern_gen_59    <= `EPCR_RST_RESERVED_EYE_CFG_B;
			r_q.phase_win  <= `EPCR_RST_EYE_PHASE_WINDOW;
			r_q.step_vert  <= `EPCR_RST_EYE_PHASE_STEP_VERT;
			r_q.rdata      <= 16'h0000;
			r_q.rate_eff   <= GEN_CTRL_RST[`EPCR_RATE_MSB:`EPCR_RATE_LSB];
			r_q.clk_rec    <= 1'b0;
			r_q.busy       <= 1'b0;
			r_q.done       <= 1'b0;
			r_q.bad        <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs are register fields; the host keeps the phase and step limits legal.
	assign host_rdata              = r_q.rdata;
	assign pattern_rate_effective  = r_q.rate_eff;
	assign pattern_clock_recovered = r_q.clk_rec;
	assign point_time_us           = {r_q.time_hi, r_q.time_lo};
	assign default_slice_level     = r_q.slice_init[`EPCR_SLICE_MSB:`EPCR_SLICE_LSB];
	assign eye_init                = r_q.slice_init[`EPCR_INIT_BIT];
	assign phase_start             = r_q.phase_win[`EPCR_PSTART_MSB:`EPCR_PSTART_LSB];
	assign phase_stop              = r_q.phase_win[`EPCR_PSTOP_MSB:`EPCR_PSTOP_LSB];
	assign phase_step              = r_q.step_vert[`EPCR_PSTEP_MSB:`EPCR_PSTEP_LSB];
	assign voltage_sweep_first     = r_q.step_vert[`EPCR_VSTART_MSB:`EPCR_VSTART_LSB];
	assign point_busy              = r_q.busy;
	assign point_done              = r_q.done;
	assign point_bad               = r_q.bad;
endmodule // epcr_config_regs

`default_nettype wire

// ===== design/epcr_point_timer.sv
// Per-point dwell timer: counts microsecond ticks over each measurement pass.
// Assumes a one-cycle start pulse and a stable programmed time during a point.
`timescale 1ns/1ps
`default_nettype none
`include "epcr_defines.svh"

module epcr_point_timer #(
	parameter int unsigned CYCLES_PER_US = `EPCR_CYCLES_PER_US
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [31:0] point_time_us,
	output logic             busy,
	output logic             done
);
	typedef struct packed {
		epcr_pkg::epcr_tmr_e st;
		logic [15:0]         presc;
		logic [31:0]         us_cnt;
		logic [1:0]          pass;
		logic                done;
	} epcr_tmr_s;

	epcr_tmr_s s_q;
	epcr_tmr_s s_d;
	logic      tick;

	// A zero microsecond setting still yields one tick per pass, so a point never hangs.
	assign tick = (s_q.presc == 16'(CYCLES_PER_US - 1));

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		unique case (s_q.st)
			epcr_pkg::EPCR_TMR_IDLE: begin
				if (start) begin
					s_d.st     = epcr_pkg::EPCR_TMR_RUN;
					s_d.presc  = 16'h0000;
					s_d.us_cnt = 32'h0000_0000;
					s_d.pass   = 2'h0;
				end
			end
			epcr_pkg::EPCR_TMR_RUN: begin
				s_d.presc = tick ? 16'h0000 : s_q.presc + 16'h0001;
				if (tick) begin
					if (s_q.us_cnt + 32'h0000_0001 >= point_time_us) begin
						s_d.us_cnt = 32'h0000_0000;
						s_d.pass   = s_q.pass + 2'h1;
						if (s_q.pass == 2'(`EPCR_POINT_PASSES - 1)) begin
							s_d.st = epcr_pkg::EPCR_TMR_DONE;
						end
					end else begin
						s_d.us_cnt = s_q.us_cnt + 32'h0000_0001;
					end
				end
			end
			epcr_pkg::EPCR_TMR_DONE: begin
				s_d.done = 1'b1;
				s_d.st   = epcr_pkg::EPCR_TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{st: epcr_pkg::EPCR_TMR_IDLE, presc: 16'h0000, us_cnt: 32'h0000_0000,
				pass: 2'h0, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = (s_q.st != epcr_pkg::EPCR_TMR_IDLE);
	assign done = s_q.done;
endmodule // epcr_point_timer

`default_nettype wire

// ===== inc/epcr_defines.svh
// Register offsets, field positions, reset values and timing counts for the eye-scan config bank.
// Assumes 16-bit registers addressed by word index on the device's serial host port.
`ifndef EPCR_DEFINES_SVH
`define EPCR_DEFINES_SVH

`define EPCR_ADDR_PATTERN_GEN_CONTROL      8'h52
`define EPCR_ADDR_RESERVED_AFTER_GEN       8'h53
`define EPCR_ADDR_EYE_POINT_TIME_HIGH      8'h54
`define EPCR_ADDR_EYE_POINT_TIME_LOW       8'h55
`define EPCR_ADDR_EYE_ERROR_THRESHOLD      8'h56
`define EPCR_ADDR_EYE_SLICE_AND_INIT       8'h57
`define EPCR_ADDR_RESERVED_EYE_CFG_A       8'h58
`define EPCR_ADDR_RESERVED_EYE_CFG_B       8'h59
`define EPCR_ADDR_EYE_PHASE_WINDOW         8'h5a
`define EPCR_ADDR_EYE_PHASE_STEP_VERT      8'h5b

`define EPCR_RST_PATTERN_GEN_CONTROL       16'h0106
`define EPCR_RST_RESERVED_AFTER_GEN        16'h0000
`define EPCR_RST_EYE_POINT_TIME_HIGH       16'h0000
`define EPCR_RST_EYE_POINT_TIME_LOW        16'h0064
`define EPCR_RST_EYE_ERROR_THRESHOLD       16'h0064
`define EPCR_RST_EYE_SLICE_AND_INIT        16'h8002
`define EPCR_RST_RESERVED_EYE_CFG_A        16'hd982
`define EPCR_RST_RESERVED_EYE_CFG_B        16'h0100
`define EPCR_RST_EYE_PHASE_WINDOW          16'h007f
`define EPCR_RST_EYE_PHASE_STEP_VERT       16'h0100

`define EPCR_RATE_LSB                      0
`define EPCR_RATE_MSB                      2
`define EPCR_CLKSRC_LSB                    6
`define EPCR_CLKSRC_MSB                    7
`define EPCR_CLKSRC_RECOVERED              2'h3
`define EPCR_INIT_BIT                      2
`define EPCR_SLICE_LSB                     8
`define EPCR_SLICE_MSB                     15
`define EPCR_PSTART_LSB                    8
`define EPCR_PSTART_MSB                    14
`define EPCR_PSTOP_LSB                     0
`define EPCR_PSTOP_MSB                     6
`define EPCR_PSTEP_LSB                     8
`define EPCR_PSTEP_MSB                     14
`define EPCR_VSTART_LSB                    0
`define EPCR_VSTART_MSB                    6

`define EPCR_POINT_PASSES                  2
`define EPCR_US_NS                         1000
`define EPCR_CLK_PERIOD_NS                 5
`define EPCR_CYCLES_PER_US                 (`EPCR_US_NS / `EPCR_CLK_PERIOD_NS)

`endif

// ===== inc/epcr_pkg.sv
// Types shared by the eye-scan config bank and its point timer.
// Assumes the defines header is compiled alongside.
package epcr_pkg;
	typedef enum logic [2:0] {
		EPCR_TMR_IDLE = 3'b001,
		EPCR_TMR_RUN  = 3'b010,
		EPCR_TMR_DONE = 3'b100
	} epcr_tmr_e;

	typedef logic [15:0] epcr_word_t;
endpackage

// ===== sim/epcr_config_regs_assertions.sv
// Port-level checks for the eye-scan config bank.
// Assumes it is bound to epcr_config_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module epcr_assertions #(
	parameter int unsigned CYCLES_PER_US = 200
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [7:0]  host_addr,
	input wire logic        host_wr,
	input wire logic [15:0] host_wdata,
	input wire logic [2:0]  cdr_rate,
	input wire logic        point_start,
	input wire logic [2:0]  pattern_rate_effective,
	input wire logic        pattern_clock_recovered,
	input wire logic [31:0] point_time_us,
	input wire logic [7:0]  default_slice_level,
	input wire logic        eye_init,
	input wire logic [6:0]  phase_start,
	input wire logic [6:0]  phase_stop,
	input wire logic        point_busy,
	input wire logic        point_done,
	input wire logic        point_bad
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_wr(a); host_wr && host_addr == a; endsequence
	sequence s_run; $rose(point_busy); endsequence
	AST_RATE_CDR: assert property (
		pattern_clock_recovered && $past(pattern_clock_recovered)
		|-> pattern_rate_effective == $past(cdr_rate)) else $error("rate not cdr");
	AST_HIGH_WR: assert property (
		s_wr(8'h54) |=> point_time_us[31:16] == $past(host_wdata))
		else $error("time high");
	AST_LOW_WR: assert property (
		s_wr(8'h55) |=> point_time_us[15:0] == $past(host_wdata))
		else $error("time low");
	AST_SLICE_WR: assert property (
		s_wr(8'h57) |=> default_slice_level == $past(host_wdata[15:8])
		&& eye_init == $past(host_wdata[2])) else $error("slice");
	AST_PHASE_WR: assert property (
		s_wr(8'h5a) |=> phase_start == $past(host_wdata[14:8])
		&& phase_stop == $past(host_wdata[6:0])) else $error("phase");
	AST_CFG_HOLD: assert property (
		!$past(host_wr) |-> $stable({point_time_us, default_slice_level, eye_init,
		phase_start, phase_stop})) else $error("drift");
	// The bound is only valid for the short point times the bench programs.
	AST_DONE_BOUND: assert property (
		s_run |-> ##[1:600] point_done) else $error("no done");
	AST_DONE_PULSE: assert property (point_done |=> !point_done) else $error("long done");
	AST_BAD_CLR: assert property (
		point_start && !point_busy && !point_done |=> !point_bad) else $error("bad kept");
	AST_BAD_AT_DONE: assert property (
		$rose(point_bad) |-> point_done) else $error("bad early");
endmodule // epcr_assertions
bind epcr_config_regs epcr_assertions #(.CYCLES_PER_US(CYCLES_PER_US)) u_ast (
	.clk_sys(clk_sys), .reset_n(reset_n), .host_addr(host_addr), .host_wr(host_wr),
	.host_wdata(host_wdata), .cdr_rate(cdr_rate), .point_start(point_start),
	.pattern_rate_effective(pattern_rate_effective), .eye_init(eye_init),
	.pattern_clock_recovered(pattern_clock_recovered), .point_time_us(point_time_us),
	.default_slice_level(default_slice_level), .phase_start(phase_start),
	.phase_stop(phase_stop), .point_busy(point_busy), .point_done(point_done),
	.point_bad(point_bad));
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the eye-scan config bank against a register mirror.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int CPU = 2;
	logic        clk_sys = 0, reset_n = 0, host_wr = 0, host_rd = 0, point_start = 0;
	logic        shape_scan = 0, pcr, eye_init, point_busy, point_done, point_bad;
	logic [7:0]  host_addr = 0, slice, a8;
	logic [15:0] host_wdata = 0, errs = 0, host_rdata, wd;
	logic [2:0]  cdr_rate = 1, rate_eff;
	logic [31:0] ptime;
	logic [6:0]  pst, psp, pss, vsf;
	logic [15:0] m [10] = '{16'h0106, 0, 0, 16'h0064, 16'h0064, 16'h8002, 16'hd982,
		16'h0100, 16'h007f, 16'h0100};
	int          error_cnt = 0, n_compared = 0, n, lo;
	epcr_config_regs #(.CYCLES_PER_US(CPU)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
		.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
		.cdr_rate(cdr_rate), .point_start(point_start), .shape_scan(shape_scan),
		.point_error_count(errs), .host_rdata(host_rdata), .pattern_rate_effective(rate_eff),
		.pattern_clock_recovered(pcr), .point_time_us(ptime), .default_slice_level(slice),
		.eye_init(eye_init), .phase_start(pst), .phase_stop(psp), .phase_step(pss),
		.voltage_sweep_first(vsf), .point_busy(point_busy), .point_done(point_done),
		.point_bad(point_bad));
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Each access leaves an idle cycle so no strobe is set twice in one step.
	task automatic wr(logic [7:0] a, logic [15:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1;
		@(negedge clk_sys);
		host_wr = 0;
		if (a >= 8'h52 && a <= 8'h5b) m[a - 8'h52] = d;
		@(negedge clk_sys);
	endtask
	task automatic rd(logic [7:0] a);
		host_addr = a;
		host_rd = 1;
		@(negedge clk_sys);
		host_rd = 0;
		check("rdata", host_rdata, (a >= 8'h52 && a <= 8'h5b) ? m[a - 8'h52] : 0);
		@(negedge clk_sys);
	endtask
	task automatic outs();
		check("time", ptime, {m[2], m[3]});
		check("slice", {slice, eye_init}, {m[5][15:8], m[5][2]});
		check("phase", {pst, psp, pss, vsf}, {m[8][14:8], m[8][6:0], m[9][14:8], m[9][6:0]});
		check("rate", rate_eff, m[0][7:6] == 3 ? cdr_rate : m[0][2:0]);
		check("src", pcr, m[0][7:6] == 3);
	endtask
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
	initial begin
		void'($urandom(68));
		repeat (6) @(negedge clk_sys);
		reset_n = 1;
		for (int a = 8'h50; a < 8'h5e; a++) rd(8'(a));
		outs();
		wr(8'h57, 16'h8006);
		for (int i = 0; i < 40; i++) begin
			cdr_rate = 3'(1 + $urandom % 6);
			a8 = 8'(8'h50 + $urandom % 14);
			wd = 16'($urandom);
			// The host keeps reserved words and the scan limits legal; the bank never checks.
			if (a8 inside {8'h53, 8'h58, 8'h59}) a8 = 8'h56;
			case (a8)
				8'h52: wd = {6'h00, wd[9:8], {2{wd[7]}}, wd[5:3], cdr_rate};
				8'h57: wd = {wd[15:8], 8'h06};
				8'h5a: begin
					wd = {1'b0, 7'($urandom % 128), 8'h00};
					wd[6:0] = 7'(wd[14:8] + $urandom % (128 - wd[14:8]));
				end
				8'h5b: wd = {8'h01, 1'b0, wd[6:0]};
				8'h54, 8'h55, 8'h56: ;
				default: wd = 16'h0000;
			endcase
			wr(a8, wd);
			outs();
			rd(8'(8'h50 + $urandom % 14));
		end
		for (int s = 0; s < 4; s++) for (int r = 1; r < 7; r++) begin
			cdr_rate = 3'(7 - r);
			wr(8'h52, 16'(s * 64 + r));
			outs();
		end
		wr(8'h5a, 16'h007f);
		wr(8'h5b, 16'h0100);
		wr(8'h56, 16'(1 + $urandom % 1000));
		for (int k = 0; k < 6; k++) begin
			wr(8'h54, 0);
			wr(8'h55, 16'(k));
			shape_scan = k < 3;
			errs = m[4] - 1 + 16'(k % 3);
			point_start = 1;
			@(negedge clk_sys);
			point_start = 0;
			repeat (2) @(negedge clk_sys);
			point_start = 1;
			@(negedge clk_sys);
			point_start = 0;
			n = 4;
			check("busy", point_busy, 1);
			while (point_done !== 1'b1 && n < 100) begin
				@(negedge clk_sys);
				n++;
			end
			lo = 2 * (k == 0 ? 1 : k) * CPU;
			check("dur", n >= lo && n <= lo + 6, 1);
			check("bad", point_bad, k == 2);
			repeat (3) @(negedge clk_sys);
			check("idle", point_busy, 0);
		end
		finish_test();
	end
endmodule // tb
`default_nettype wire
